// >>> core/aec_params.svh
// Purpose: named constants of the asynchronous event counter
// Assumes: included by its bare name
// Notes: register indices; byte address is four times the index
`ifndef AEC_PARAMS_SVH
`define AEC_PARAMS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define AEC_IDX_PCMP_H 16'hFF8C
`define AEC_IDX_PCMP_L 16'hFF8D
`define AEC_IDX_DATA_H 16'hFF8E
`define AEC_IDX_DATA_L 16'hFF8F
`define AEC_IDX_EDGE 16'hFF92
`define AEC_IDX_CLKCTL 16'hFF94
`define AEC_IDX_CTLSTAT 16'hFF95
`define AEC_IDX_CNT_H 16'hFF96
`define AEC_IDX_CNT_L 16'hFF97
`define AEC_IDX_CKSTP 16'hFFFB
`define AEC_IDX_LSB 2
`define AEC_IDX_MSB 17

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AEC_RST_ONES 8'hFF
`define AEC_RST_ZERO 8'h00
`define AEC_RST_CTL 6'h00
`define AEC_CNT_MAX 8'hFF
`define AEC_CNT_ONE 8'h01

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AEC_ES_HI_MSB 7
`define AEC_ES_HI_LSB 6
`define AEC_ES_LO_MSB 5
`define AEC_ES_LO_LSB 4
`define AEC_ES_IRQ_MSB 3
`define AEC_ES_IRQ_LSB 2
`define AEC_PWM_EN_BIT 1
`define AEC_CK_HI_MSB 7
`define AEC_CK_HI_LSB 6
`define AEC_CK_LO_MSB 5
`define AEC_CK_LO_LSB 4
`define AEC_CK_PWM_MSB 3
`define AEC_CK_PWM_LSB 1
`define AEC_OVH_BIT 7
`define AEC_OVL_BIT 6
`define AEC_CTL_MSB 5
`define AEC_TWO_CH_BIT 4
`define AEC_CUE_H_BIT 3
`define AEC_CUE_L_BIT 2
`define AEC_CRC_H_BIT 1
`define AEC_CRC_L_BIT 0
`define AEC_RUN_BIT 3

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define AEC_EDGE_FALL 2'h0
`define AEC_EDGE_RISE 2'h1
`define AEC_EDGE_BOTH 2'h2
`define AEC_CLK_PIN 2'h0
`define AEC_CLK_DIV2 2'h1
`define AEC_CLK_DIV4 2'h2
`define AEC_CLK_DIV8 2'h3
`define AEC_RESP_OKAY 2'h0
`define AEC_RESP_SLVERR 2'h2
`define AEC_PWM_ONE 16'h0001
`define AEC_PWM_ZERO 16'h0000
`define AEC_PSC_ONE 6'h01

`endif

// >>> core/aec_pkg.sv
// Purpose: types of the asynchronous event counter
// Assumes: nothing
// Notes: whole module state is one packed struct
package aec_pkg;

    typedef struct packed {
        logic [7:0] pcmp_h;
        logic [7:0] pcmp_l;
        logic [7:0] data_h;
        logic [7:0] data_l;
        logic [7:0] edge_sel;
        logic [7:0] clk_ctl;
        logic [5:0] ctl;
        logic ov_h;
        logic ov_l;
        logic ov_h_arm;
        logic ov_l_arm;
        logic [7:0] cnt_h;
        logic [7:0] cnt_l;
        logic [7:0] ckstp;
        logic [5:0] psc;
        logic [15:0] pwm_cnt;
        logic pwm_out;
        logic [1:0] hi_sync;
        logic [1:0] lo_sync;
        logic [1:0] irq_sync;
        logic hi_prev;
        logic lo_prev;
        logic gate_prev;
        logic irq_gate;
        logic irq_ovh;
        logic irq_ovl;
        logic aw_got;
        logic w_got;
        logic [15:0] aw_idx;
        logic [7:0] wdata;
        logic wstb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } aec_state_t;

endpackage

// >>> core/aec_top.sv
// Purpose: asynchronous event counter with gate waveform and AXI4-Lite registers
// Assumes: one 100 MHz clock, asynchronous active-low reset
// Notes: event pins pass through two-flop synchronisers before edge detection
`timescale 1ns/1ps
`include "aec_params.svh"

module aec_top
    import aec_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // event pins
    input wire logic event_pin_high_i,
    input wire logic event_pin_low_i,
    input wire logic event_enable_irq_pin_i,
    // waveform and interrupt requests
    output logic gate_waveform_output_o,
    output logic gate_edge_irq_o,
    output logic overflow_high_irq_o,
    output logic overflow_low_irq_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        logic hit;
        hit = 1'b0;
        case (sel)
            `AEC_EDGE_FALL: hit = prev & ~cur;
            `AEC_EDGE_RISE: hit = ~prev & cur;
            `AEC_EDGE_BOTH: hit = prev ^ cur;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic div_tick(input logic [1:0] sel, input logic [5:0] p);
        logic t;
        t = 1'b0;
        case (sel)
            `AEC_CLK_DIV2: t = p[0];
            `AEC_CLK_DIV4: t = &p[1:0];
            `AEC_CLK_DIV8: t = &p[2:0];
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic pwm_tick(input logic [2:0] sel, input logic [5:0] p);
        logic t;
        t = 1'b0;
        case (sel)
            3'h0: t = p[0];
            3'h1: t = &p[1:0];
            3'h2: t = &p[2:0];
            3'h3: t = &p[3:0];
            3'h4: t = &p[4:0];
            3'h6: t = &p[4:0];
            default: t = &p[5:0];
        endcase
        return t;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    aec_state_t s;
    aec_state_t next_s;

    logic running;
    logic gate;
    logic tick_h;
    logic tick_l;
    logic inc_l;
    logic inc_h;
    logic ovl_evt;
    logic ovh_evt;
    logic [15:0] pwm_period;
    logic [15:0] pwm_data;
    logic do_write;
    logic [15:0] ar_idx;
    logic [7:0] rd_val;
    logic rd_ok;
    logic wr_ok;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        running = s.ckstp[`AEC_RUN_BIT];
        pwm_period = {s.pcmp_h, s.pcmp_l};
        pwm_data = {s.data_h, s.data_l};

        // synchronisers, first stage read only by the second
        next_s.hi_sync = {s.hi_sync[0], event_pin_high_i};
        next_s.lo_sync = {s.lo_sync[0], event_pin_low_i};
        next_s.irq_sync = {s.irq_sync[0], event_enable_irq_pin_i};
        next_s.hi_prev = s.hi_sync[1];
        next_s.lo_prev = s.lo_sync[1];

        // prescaler halts in standby
        if (running) begin
            next_s.psc = s.psc + `AEC_PSC_ONE;
        end

        // gate waveform
        if (running && s.edge_sel[`AEC_PWM_EN_BIT]) begin
            if (pwm_tick(s.clk_ctl[`AEC_CK_PWM_MSB:`AEC_CK_PWM_LSB], s.psc)) begin
                if (s.pwm_cnt >= pwm_period) begin
                    next_s.pwm_cnt = `AEC_PWM_ZERO;
                end else begin
                    next_s.pwm_cnt = s.pwm_cnt + `AEC_PWM_ONE;
                end
            end
            next_s.pwm_out = (s.pwm_cnt >= pwm_data);
        end else if (!s.edge_sel[`AEC_PWM_EN_BIT]) begin
            next_s.pwm_cnt = `AEC_PWM_ZERO;
            next_s.pwm_out = 1'b0;
        end

        // gate selection
        gate = s.edge_sel[`AEC_PWM_EN_BIT] ? s.pwm_out : s.irq_sync[1];
        next_s.gate_prev = gate;
        next_s.irq_gate = running && edge_hit(s.edge_sel[`AEC_ES_IRQ_MSB:`AEC_ES_IRQ_LSB],
                                              s.gate_prev, gate);

        // clock sources per half
        if (s.clk_ctl[`AEC_CK_HI_MSB:`AEC_CK_HI_LSB] == `AEC_CLK_PIN) begin
            tick_h = edge_hit(s.edge_sel[`AEC_ES_HI_MSB:`AEC_ES_HI_LSB],
                              s.hi_prev, s.hi_sync[1]);
        end else begin
            tick_h = div_tick(s.clk_ctl[`AEC_CK_HI_MSB:`AEC_CK_HI_LSB], s.psc);
        end
        if (s.clk_ctl[`AEC_CK_LO_MSB:`AEC_CK_LO_LSB] == `AEC_CLK_PIN) begin
            tick_l = edge_hit(s.edge_sel[`AEC_ES_LO_MSB:`AEC_ES_LO_LSB],
                              s.lo_prev, s.lo_sync[1]);
        end else begin
            tick_l = div_tick(s.clk_ctl[`AEC_CK_LO_MSB:`AEC_CK_LO_LSB], s.psc);
        end
        tick_h = tick_h & gate & running;
        tick_l = tick_l & gate & running;

        // counters
        inc_l = tick_l & s.ctl[`AEC_CUE_L_BIT] & s.ctl[`AEC_CRC_L_BIT];
        if (s.ctl[`AEC_TWO_CH_BIT]) begin
            inc_h = tick_h & s.ctl[`AEC_CUE_H_BIT];
        end else begin
            inc_h = inc_l & (s.cnt_l == `AEC_CNT_MAX) & s.ctl[`AEC_CUE_H_BIT];
        end
        inc_h = inc_h & s.ctl[`AEC_CRC_H_BIT];
        ovl_evt = inc_l & (s.cnt_l == `AEC_CNT_MAX);
        ovh_evt = inc_h & (s.cnt_h == `AEC_CNT_MAX);
        if (!s.ctl[`AEC_CRC_L_BIT]) begin
            next_s.cnt_l = `AEC_RST_ZERO;
        end else if (inc_l) begin
            next_s.cnt_l = s.cnt_l + `AEC_CNT_ONE;
        end
        if (!s.ctl[`AEC_CRC_H_BIT]) begin
            next_s.cnt_h = `AEC_RST_ZERO;
        end else if (inc_h) begin
            next_s.cnt_h = s.cnt_h + `AEC_CNT_ONE;
        end
        next_s.irq_ovh = ovh_evt;
        next_s.irq_ovl = ovl_evt;

        // axi write channels, taken in either order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_s.aw_got = 1'b1;
            next_s.aw_idx = s_axi_awaddr_i[`AEC_IDX_MSB:`AEC_IDX_LSB];
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata_i[7:0];
            next_s.wstb = s_axi_wstrb_i[0];
        end
        if (s.bvalid && s_axi_bready_i) begin
            next_s.bvalid = 1'b0;
        end
        do_write = s.aw_got & s.w_got & ~s.bvalid;

        // axi read, answer one cycle after acceptance
        ar_idx = s_axi_araddr_i[`AEC_IDX_MSB:`AEC_IDX_LSB];
        rd_ok = 1'b1;
        rd_val = `AEC_RST_ZERO;
        if (ar_idx == `AEC_IDX_PCMP_H) begin
            rd_val = s.pcmp_h;
        end else if (ar_idx == `AEC_IDX_PCMP_L) begin
            rd_val = s.pcmp_l;
        end else if (ar_idx == `AEC_IDX_DATA_H || ar_idx == `AEC_IDX_DATA_L) begin
            rd_val = `AEC_RST_ZERO;
        end else if (ar_idx == `AEC_IDX_EDGE) begin
            rd_val = s.edge_sel;
        end else if (ar_idx == `AEC_IDX_CLKCTL) begin
            rd_val = s.clk_ctl;
        end else if (ar_idx == `AEC_IDX_CTLSTAT) begin
            rd_val = {s.ov_h, s.ov_l, s.ctl};
        end else if (ar_idx == `AEC_IDX_CNT_H) begin
            rd_val = s.cnt_h;
        end else if (ar_idx == `AEC_IDX_CNT_L) begin
            rd_val = s.cnt_l;
        end else if (ar_idx == `AEC_IDX_CKSTP) begin
            rd_val = s.ckstp;
        end else begin
            rd_ok = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_val;
            next_s.rresp = rd_ok ? `AEC_RESP_OKAY : `AEC_RESP_SLVERR;
            if (rd_ok && ar_idx == `AEC_IDX_CTLSTAT) begin
                next_s.ov_h_arm = s.ov_h_arm | s.ov_h;
                next_s.ov_l_arm = s.ov_l_arm | s.ov_l;
            end
        end else if (s.rvalid && s_axi_rready_i) begin
            next_s.rvalid = 1'b0;
        end

        // register writes
        wr_ok = 1'b1;
        if (do_write) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            if (s.aw_idx == `AEC_IDX_PCMP_H) begin
                if (s.wstb) next_s.pcmp_h = s.wdata;
            end else if (s.aw_idx == `AEC_IDX_PCMP_L) begin
                if (s.wstb) next_s.pcmp_l = s.wdata;
            end else if (s.aw_idx == `AEC_IDX_DATA_H) begin
                if (s.wstb) next_s.data_h = s.wdata;
            end else if (s.aw_idx == `AEC_IDX_DATA_L) begin
                if (s.wstb) next_s.data_l = s.wdata;
            end else if (s.aw_idx == `AEC_IDX_EDGE) begin
                if (s.wstb) next_s.edge_sel = s.wdata;
            end else if (s.aw_idx == `AEC_IDX_CLKCTL) begin
                if (s.wstb) next_s.clk_ctl = s.wdata;
            end else if (s.aw_idx == `AEC_IDX_CTLSTAT) begin
                if (s.wstb) begin
                    next_s.ctl = s.wdata[`AEC_CTL_MSB:0];
                    if (!s.wdata[`AEC_OVH_BIT] && s.ov_h_arm) begin
                        next_s.ov_h = 1'b0;
                    end
                    if (!s.wdata[`AEC_OVL_BIT] && s.ov_l_arm) begin
                        next_s.ov_l = 1'b0;
                    end
                    next_s.ov_h_arm = 1'b0;
                    next_s.ov_l_arm = 1'b0;
                end
            end else if (s.aw_idx == `AEC_IDX_CKSTP) begin
                if (s.wstb) next_s.ckstp = s.wdata;
            end else if (s.aw_idx == `AEC_IDX_CNT_H || s.aw_idx == `AEC_IDX_CNT_L) begin
                wr_ok = 1'b1;
            end else begin
                wr_ok = 1'b0;
            end
            next_s.bresp = wr_ok ? `AEC_RESP_OKAY : `AEC_RESP_SLVERR;
        end

        // overflow set wins over a clear in the same cycle
        if (ovh_evt) begin
            next_s.ov_h = 1'b1;
        end
        if (ovl_evt) begin
            next_s.ov_l = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
            s.pcmp_h <= `AEC_RST_ONES;
            s.pcmp_l <= `AEC_RST_ONES;
            s.ckstp <= `AEC_RST_ONES;
            s.ctl <= `AEC_RST_CTL;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready_o = ~s.aw_got & ~s.bvalid;
    assign s_axi_wready_o = ~s.w_got & ~s.bvalid;
    assign s_axi_bvalid_o = s.bvalid;
    assign s_axi_bresp_o = s.bresp;
    assign s_axi_arready_o = ~s.rvalid;
    assign s_axi_rvalid_o = s.rvalid;
    assign s_axi_rresp_o = s.rresp;
    assign s_axi_rdata_o = {24'h000000, s.rdata};
    assign gate_waveform_output_o = s.pwm_out;
    assign gate_edge_irq_o = s.irq_gate;
    assign overflow_high_irq_o = s.irq_ovh;
    assign overflow_low_irq_o = s.irq_ovl;

endmodule

// >>> verification/aec_evt_src.sv
// Purpose: model of the event sources and the gate pin
// Assumes: pins idle high, gate pin starts low
// Notes: every pulse level is held three clocks so the synchronisers see it
`timescale 1ns/1ps

module aec_evt_src (
    // clock
    input wire logic clock_i,
    // pins
    output logic hi_o,
    output logic lo_o,
    output logic en_o
);
    initial begin
        hi_o = 1'b1;
        lo_o = 1'b1;
        en_o = 1'b0;
    end

    // one pulse is a falling then a rising edge
    task automatic pulse(input bit sel, input int n);
        repeat (n) begin
            if (sel) hi_o <= 1'b0; else lo_o <= 1'b0;
            repeat (3) @(posedge clock_i);
            if (sel) hi_o <= 1'b1; else lo_o <= 1'b1;
            repeat (3) @(posedge clock_i);
        end
    endtask

    task automatic set_en(input logic v);
        en_o <= v;
        @(posedge clock_i);
    endtask
endmodule

// >>> verification/aec_chk.sv
// Purpose: concurrent checks at the ports of aec_top
// Assumes: single clock domain
// Notes: bound into aec_top below
`timescale 1ns/1ps

module aec_chk (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // bus
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    // pins
    input wire logic event_enable_irq_pin_i,
    input wire logic gate_waveform_output_o,
    input wire logic gate_edge_irq_o,
    input wire logic overflow_high_irq_o,
    input wire logic overflow_low_irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // -------------------------------------------
    // sequences
    // -------------------------------------------
    sequence s_wr_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_gate_shut;
        (!event_enable_irq_pin_i && !gate_waveform_output_o) [*6];
    endsequence

    // -------------------------------------------
    // assertions
    // -------------------------------------------
    AST_WR_ANSWER: assert property (s_wr_take |=> ##1 s_axi_bvalid_o)
        else $error("write response late");
    AST_RD_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response late");
    AST_B_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while response pending");
    AST_R_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while data pending");
    AST_R_UPPER: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
        else $error("read data wider than a byte");
    AST_OVH_PULSE: assert property ($rose(overflow_high_irq_o) |=> !overflow_high_irq_o)
        else $error("high overflow request not a pulse");
    AST_OVL_PULSE: assert property ($rose(overflow_low_irq_o) |=> !overflow_low_irq_o)
        else $error("low overflow request not a pulse");
    AST_GATE_PULSE: assert property (gate_edge_irq_o |=> !gate_edge_irq_o)
        else $error("gate edge request not a pulse");
    AST_GATE_SHUT: assert property (s_gate_shut |-> !overflow_low_irq_o && !overflow_high_irq_o)
        else $error("count moved while gate closed");
endmodule

bind aec_top aec_chk i_chk (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .event_enable_irq_pin_i(event_enable_irq_pin_i),
    .gate_waveform_output_o(gate_waveform_output_o),
    .gate_edge_irq_o(gate_edge_irq_o),
    .overflow_high_irq_o(overflow_high_irq_o),
    .overflow_low_irq_o(overflow_low_irq_o)
);

// >>> verification/aec_top_tb.sv
// Purpose: self-checking bench of aec_top
// Assumes: bready and rready held high throughout
// Notes: bus inputs sampled at the falling edge, driven after the rising edge
`timescale 1ns/1ps
`include "aec_params.svh"

module aec_top_tb;
    import aec_pkg::*;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic [31:0] araddr = 32'h0;
    logic arvalid = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, hi, lo, en, wave, girq_p, ovh_p, ovl_p;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int fails = 0;
    int tests_run = 0;
    int oh = 0;
    int ol = 0;
    int gi = 0;

    initial forever #5 clock_i = ~clock_i;

    aec_evt_src i_src (.clock_i(clock_i), .hi_o(hi), .lo_o(lo), .en_o(en));

    aec_top i_dut (
        .clock_i(clock_i), .rstn_i(rstn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .event_pin_high_i(hi), .event_pin_low_i(lo), .event_enable_irq_pin_i(en),
        .gate_waveform_output_o(wave), .gate_edge_irq_o(girq_p),
        .overflow_high_irq_o(ovh_p), .overflow_low_irq_o(ovl_p)
    );

    // pulse counters, updated late so waiters see the old count at the edge
    always @(posedge clock_i) begin
        if (ovh_p === 1'b1) oh <= oh + 1;
        if (ovl_p === 1'b1) ol <= ol + 1;
        if (girq_p === 1'b1) gi <= gi + 1;
    end

    // -------------------------------------------
    // shared tasks
    // -------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic ta, tw, tb;
        awaddr <= {14'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clock_i);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            if (tb) chk("bresp", `AEC_RESP_OKAY, bresp);
            @(posedge clock_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask

    task automatic rd(input logic [15:0] idx, output logic [7:0] d, input logic [1:0] er);
        logic ta, tr;
        araddr <= {14'h0, idx, 2'h0};
        arvalid <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clock_i);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata[7:0];
            if (tr) chk("rresp", er, rresp);
            @(posedge clock_i);
            if (ta) arvalid <= 1'b0;
        end
    endtask

    task automatic rc(input logic [15:0] idx, input logic [7:0] e);
        logic [7:0] d;
        rd(idx, d, `AEC_RESP_OKAY);
        chk("rdata", {24'h0, e}, {24'h0, d});
    endtask

    // cycles between two overflow pulses of one half
    task automatic period(input bit h, input int e);
        int c0, n;
        c0 = h ? oh : ol;
        wait ((h ? oh : ol) != c0);
        c0 = h ? oh : ol;
        n = -1;
        while ((h ? oh : ol) == c0) begin
            @(posedge clock_i);
            n++;
        end
        chk("period", e, n);
    endtask

    task automatic restart(input logic [7:0] c);
        wr(`AEC_IDX_CTLSTAT, 8'h10);
        wr(`AEC_IDX_CTLSTAT, c);
    endtask

    // -------------------------------------------
    // scenarios
    // -------------------------------------------
    task automatic sc_regs();
        logic [15:0] ix [10] = '{16'hFF8C, 16'hFF8D, 16'hFF8E, 16'hFF8F, 16'hFF92,
            16'hFF94, 16'hFF95, 16'hFF96, 16'hFF97, 16'hFFFB};
        logic [7:0] rv [10] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'hFF};
        logic [7:0] d;
        foreach (ix[i]) rc(ix[i], rv[i]);
        rd(16'hFF90, d, `AEC_RESP_SLVERR);
        chk("unmapped", 32'h0, {24'h0, d});
        wr(`AEC_IDX_CNT_H, 8'h55);
        rc(`AEC_IDX_CNT_H, 8'h00);
        wr(`AEC_IDX_PCMP_H, 8'h5A);
        rc(`AEC_IDX_PCMP_H, 8'h5A);
        wr(`AEC_IDX_DATA_H, 8'h33);
        rc(`AEC_IDX_DATA_H, 8'h00);
        // a write with its byte lane off stores nothing
        wstrb <= 4'h0;
        wr(`AEC_IDX_PCMP_H, 8'h77);
        wstrb <= 4'hF;
        rc(`AEC_IDX_PCMP_H, 8'h5A);
    endtask

    task automatic sc_gate_shut();
        wr(`AEC_IDX_CLKCTL, 8'h50);
        restart(8'h1F);
        repeat (100) @(posedge clock_i);
        rc(`AEC_IDX_CNT_L, 8'h00);
        i_src.set_en(1'b1);
        restart(8'h1B);
        repeat (100) @(posedge clock_i);
        rc(`AEC_IDX_CNT_L, 8'h00);
    endtask

    task automatic sc_standby();
        logic [7:0] d;
        wr(`AEC_IDX_CKSTP, 8'hF7);
        restart(8'h1F);
        repeat (100) @(posedge clock_i);
        rc(`AEC_IDX_CNT_L, 8'h00);
        wr(`AEC_IDX_CKSTP, 8'hFF);
        repeat (100) @(posedge clock_i);
        rd(`AEC_IDX_CNT_L, d, `AEC_RESP_OKAY);
        chk("running", 32'h1, {31'h0, d != 8'h00});
    endtask

    task automatic sc_edges();
        int m [4] = '{1, 1, 2, 0};
        wr(`AEC_IDX_CLKCTL, 8'h00);
        for (int e = 0; e < 4; e++) begin
            wr(`AEC_IDX_EDGE, {e[1:0], e[1:0], 4'h0});
            restart(8'h1F);
            i_src.pulse(1'b1, 3);
            i_src.pulse(1'b0, 5);
            repeat (6) @(posedge clock_i);
            rc(`AEC_IDX_CNT_H, 8'(3 * m[e]));
            rc(`AEC_IDX_CNT_L, 8'(5 * m[e]));
        end
    endtask

    task automatic sc_gate_irq();
        int m [4] = '{1, 1, 2, 0};
        int g0;
        wr(`AEC_IDX_CTLSTAT, 8'h10);
        for (int e = 0; e < 4; e++) begin
            wr(`AEC_IDX_EDGE, {4'h0, e[1:0], 2'h0});
            repeat (6) @(posedge clock_i);
            g0 = gi;
            i_src.set_en(1'b0);
            repeat (6) @(posedge clock_i);
            i_src.set_en(1'b1);
            repeat (6) @(posedge clock_i);
            chk("gate_irqs", m[e], gi - g0);
        end
    endtask

    task automatic sc_prescale();
        restart(8'h1F);
        for (int k = 1; k < 4; k++) begin
            wr(`AEC_IDX_CLKCTL, {k[1:0], k[1:0], 4'h0});
            period(1'b0, 256 << k);
            period(1'b1, 256 << k);
        end
        restart(8'h0F);
        wait (ol != 0);
        period(1'b0, 2048);
        rc(`AEC_IDX_CNT_H, 8'h02);
        wr(`AEC_IDX_CTLSTAT, 8'h10);
        rc(`AEC_IDX_CTLSTAT, 8'hD0);
        wr(`AEC_IDX_CTLSTAT, 8'h10);
        rc(`AEC_IDX_CTLSTAT, 8'h10);
    endtask

    task automatic sc_wave();
        int n;
        // waveform halted before its registers change
        wr(`AEC_IDX_EDGE, 8'h00);
        wr(`AEC_IDX_PCMP_H, 8'h00);
        wr(`AEC_IDX_PCMP_L, 8'h03);
        wr(`AEC_IDX_DATA_H, 8'h00);
        wr(`AEC_IDX_DATA_L, 8'h02);
        wr(`AEC_IDX_CLKCTL, 8'h00);
        wr(`AEC_IDX_EDGE, 8'h02);
        repeat (16) @(posedge clock_i);
        n = 0;
        repeat (64) begin
            @(negedge clock_i);
            if (wave === 1'b1) n++;
        end
        chk("wave_high", 32, n);
        wr(`AEC_IDX_EDGE, 8'h00);
        repeat (4) @(posedge clock_i);
        chk("wave_off", 1'b0, wave);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock_i);
        fails++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        sc_regs();
        sc_gate_shut();
        sc_standby();
        sc_edges();
        sc_gate_irq();
        sc_prescale();
        sc_wave();
        final_report();
    end
endmodule
